// *** logic/branch_condition_evaluator.v ***
`timescale 1ns/1ps
`include "branch_condition_map.vh"

// Notes on behaviour
// [RULE1] Condition field is opcode bits 7 to 4.
// [RULE2] Jump only when selected test is true.
// [RULE3] Code 0 never jumps, code 8 always.
// [RULE4] Code 1 sign xor overflow; 9 equal.
// [RULE5] Code 2 zero or sign/overflow differ.
// [RULE6] Code A zero clear, sign equals overflow.
// [RULE7] Code 3 carry or zero set.
// [RULE8] Code B carry and zero both clear.
// [RULE9] Code 4 overflow set, C overflow clear.
// [RULE10] Code 5 sign set, D sign clear.
// [RULE11] Code 6 zero set, E zero clear.
// [RULE12] Code 7 carry set, F carry clear.
// [RULE13] Purely combinational on committed flag values.
module branch_condition_evaluator #(
   parameter ADDR_WIDTH  = 12,
   parameter COUNT_WIDTH = 32
) (
   input  wire                  clk,
   input  wire                  rst,
   // APB slave.
   input  wire                  psel,
   input  wire                  penable,
   input  wire                  pwrite,
   input  wire [ADDR_WIDTH-1:0] paddr,
   input  wire [31:0]           pwdata,
   output reg  [31:0]           prdata,
   output wire                  pready,
   output reg                   pslverr,
   // Jump sequencing side.
   input  wire [7:0]            opcodeByte,
   input  wire                  carryFlag,
   input  wire                  zeroFlag,
   input  wire                  signFlag,
   input  wire                  overflowFlag,
   input  wire                  resolveStrobe,
   output wire                  jumpTaken,
   output wire [3:0]            branchConditionField
);

   // ****************************************************************
   // Functions
   // ****************************************************************

   function isMapped;
      input [ADDR_WIDTH-1:0] addr;
      begin
         case (addr)
            `OFS_CONTROL,
            `OFS_LAST_RESULT,
            `OFS_TRIAL,
            `OFS_TAKEN_COUNT,
            `OFS_RESOLVE_COUNT,
            `OFS_SEEN_CODES: isMapped = 1'b1;
            default:         isMapped = 1'b0;
         endcase
      end
   endfunction

   function [15:0] codeBit;
      input [3:0] code;
      begin
         codeBit = 16'h0001 << code;
      end
   endfunction

   // ****************************************************************
   // Declarations
   // ****************************************************************

   reg                    countEnable_ff;
   reg                    nxt_countEnable;
   reg  [7:0]             trial_ff;
   reg  [7:0]             nxt_trial;
   reg  [9:0]             lastResult_ff;
   reg  [9:0]             nxt_lastResult;
   reg  [COUNT_WIDTH-1:0] takenCount_ff;
   reg  [COUNT_WIDTH-1:0] nxt_takenCount;
   reg  [COUNT_WIDTH-1:0] resolveCount_ff;
   reg  [COUNT_WIDTH-1:0] nxt_resolveCount;
   reg  [15:0]            seenCodes_ff;
   reg  [15:0]            nxt_seenCodes;
   reg  [31:0]            nxt_prdata;
   reg                    nxt_pslverr;
   wire                   setupPhase;
   wire                   writeTaken;
   wire                   countClear;
   wire                   trialTrue;
   wire [3:0]             liveFlags;
   wire [3:0]             trialCond;

   // ****************************************************************
   // Live decision
   // ****************************************************************

   // No register sits in this path, so the decision follows the flags
   // that the core has committed in the same cycle.
   assign branchConditionField = opcodeByte[`COND_FIELD_MSB:`COND_FIELD_LSB]; // [RULE1]

   condition_flag_test liveTest (
      .condCode     (branchConditionField),
      .carryFlag    (carryFlag),
      .zeroFlag     (zeroFlag),
      .signFlag     (signFlag),
      .overflowFlag (overflowFlag),
      .testTrue     (jumpTaken)                                   // [RULE2] [RULE13]
   );

   assign liveFlags = {overflowFlag, signFlag, zeroFlag, carryFlag};

   // ****************************************************************
   // Software trial evaluation
   // ****************************************************************

   // A second copy lets software check any code against any flag set
   // without disturbing the live path.
   assign trialCond = trial_ff[`TRIAL_COND_LSB+3:`TRIAL_COND_LSB];

   condition_flag_test trialTest (
      .condCode     (trialCond),
      .carryFlag    (trial_ff[`FLAG_CARRY_BIT]),
      .zeroFlag     (trial_ff[`FLAG_ZERO_BIT]),
      .signFlag     (trial_ff[`FLAG_SIGN_BIT]),
      .overflowFlag (trial_ff[`FLAG_OVERFLOW_BIT]),
      .testTrue     (trialTrue)
   );

   // ****************************************************************
   // APB access decode
   // ****************************************************************

   assign setupPhase = psel & ~penable;
   assign writeTaken = psel & penable & pwrite;
   assign pready     = 1'b1;
   assign countClear = writeTaken && (paddr == `OFS_CONTROL) &&
                       pwdata[`CTRL_COUNT_CLR_BIT];

   // ****************************************************************
   // Register next values
   // ****************************************************************

   always @* begin
      nxt_countEnable = countEnable_ff;
      nxt_trial       = trial_ff;
      if (writeTaken) begin
         case (paddr)
            `OFS_CONTROL: begin
               nxt_countEnable = pwdata[`CTRL_COUNT_EN_BIT];
            end
            `OFS_TRIAL: begin
               nxt_trial = pwdata[7:0];
            end
            default: begin
               nxt_countEnable = countEnable_ff;
            end
         endcase
      end
   end

   // Statistics record each resolved jump, the counts only while enabled; a resolve in the same cycle
   // as a clear is kept, so the count restarts at one.
   always @* begin
      nxt_lastResult   = lastResult_ff;
      nxt_takenCount   = countClear ? {COUNT_WIDTH{1'b0}} : takenCount_ff;
      nxt_resolveCount = countClear ? {COUNT_WIDTH{1'b0}} : resolveCount_ff;
      nxt_seenCodes    = seenCodes_ff;
      if (writeTaken && (paddr == `OFS_SEEN_CODES)) begin
         nxt_seenCodes = seenCodes_ff & ~pwdata[15:0];
      end
      if (resolveStrobe) begin
         nxt_lastResult = {1'b1, jumpTaken, branchConditionField, liveFlags};
         nxt_seenCodes  = nxt_seenCodes | codeBit(branchConditionField);
         if (countEnable_ff) begin
            nxt_resolveCount = nxt_resolveCount + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
            if (jumpTaken) begin
               nxt_takenCount = nxt_takenCount + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   // Read data are sampled in the setup cycle, so the answer is ready
   // with no wait state in the access cycle.
   always @* begin
      nxt_prdata  = prdata;
      nxt_pslverr = pslverr;
      if (setupPhase) begin
         nxt_pslverr = ~isMapped(paddr);
         nxt_prdata  = 32'h0000_0000;
         case (paddr)
            `OFS_CONTROL: begin
               nxt_prdata[`CTRL_COUNT_EN_BIT] = countEnable_ff;
            end
            `OFS_LAST_RESULT: begin
               nxt_prdata[9:0] = lastResult_ff;
            end
            `OFS_TRIAL: begin
               nxt_prdata[7:0]               = trial_ff;
               nxt_prdata[`TRIAL_RESULT_BIT] = trialTrue;
            end
            `OFS_TAKEN_COUNT: begin
               nxt_prdata[COUNT_WIDTH-1:0] = takenCount_ff;
            end
            `OFS_RESOLVE_COUNT: begin
               nxt_prdata[COUNT_WIDTH-1:0] = resolveCount_ff;
            end
            `OFS_SEEN_CODES: begin
               nxt_prdata[15:0] = seenCodes_ff;
            end
            default: begin
               nxt_prdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         countEnable_ff  <= `RST_COUNT_EN;
         trial_ff        <= `RST_TRIAL;
         lastResult_ff   <= `RST_LAST;
         takenCount_ff   <= {COUNT_WIDTH{1'b0}};
         resolveCount_ff <= {COUNT_WIDTH{1'b0}};
         seenCodes_ff    <= `RST_SEEN;
         prdata          <= 32'h0000_0000;
         pslverr         <= 1'b0;
      end else begin
         countEnable_ff  <= nxt_countEnable;
         trial_ff        <= nxt_trial;
         lastResult_ff   <= nxt_lastResult;
         takenCount_ff   <= nxt_takenCount;
         resolveCount_ff <= nxt_resolveCount;
         seenCodes_ff    <= nxt_seenCodes;
         prdata          <= nxt_prdata;
         pslverr         <= nxt_pslverr;
      end
   end

endmodule // branch_condition_evaluator

// *** logic/branch_condition_map.vh ***
`ifndef BRANCH_CONDITION_MAP_VH
`define BRANCH_CONDITION_MAP_VH

// ****************************************************************
// Position of the condition field inside the opcode byte
// ****************************************************************
`define COND_FIELD_MSB         7
`define COND_FIELD_LSB         4
`define COND_FIELD_WIDTH       4

// ****************************************************************
// Condition encodings
// ****************************************************************
`define COND_NEVER             4'h0
`define COND_SIGNED_BELOW      4'h1
`define COND_SIGNED_BELOW_SAME 4'h2
`define COND_UNSIGNED_BEL_SAME 4'h3
`define COND_OVERFLOWED        4'h4
`define COND_NEGATIVE_RESULT   4'h5
`define COND_EQUAL_TEST        4'h6
`define COND_UNSIGNED_BELOW    4'h7
`define COND_ALWAYS            4'h8
`define COND_SIGNED_ABOVE_SAME 4'h9
`define COND_SIGNED_ABOVE      4'ha
`define COND_UNSIGNED_ABOVE    4'hb
`define COND_NOT_OVERFLOWED    4'hc
`define COND_POSITIVE_RESULT   4'hd
`define COND_UNEQUAL_TEST      4'he
`define COND_UNSIGNED_ABV_SAME 4'hf

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_CONTROL            12'h000
`define OFS_LAST_RESULT        12'h004
`define OFS_TRIAL              12'h008
`define OFS_TAKEN_COUNT        12'h00c
`define OFS_RESOLVE_COUNT      12'h010
`define OFS_SEEN_CODES         12'h014

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_COUNT_EN_BIT      0
`define CTRL_COUNT_CLR_BIT     1
`define FLAG_CARRY_BIT         0
`define FLAG_ZERO_BIT          1
`define FLAG_SIGN_BIT          2
`define FLAG_OVERFLOW_BIT      3
`define TRIAL_COND_LSB         4
`define TRIAL_RESULT_BIT       8
`define LAST_FLAGS_LSB         0
`define LAST_COND_LSB          4
`define LAST_TAKEN_BIT         8
`define LAST_VALID_BIT         9

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_CONTROL            32'h0000_0001
`define RST_COUNT_EN           1'b1
`define RST_LAST               10'h000
`define RST_TRIAL              8'h00
`define RST_COUNT              32'h0000_0000
`define RST_SEEN               16'h0000

`endif

// *** logic/condition_flag_test.v ***
`timescale 1ns/1ps
`include "branch_condition_map.vh"

module condition_flag_test (
   input  wire [3:0] condCode,
   input  wire       carryFlag,
   input  wire       zeroFlag,
   input  wire       signFlag,
   input  wire       overflowFlag,
   output reg        testTrue
);

   wire signedBelow;

   // Sign differing from overflow means the signed result lies below.
   assign signedBelow = signFlag ^ overflowFlag;

   always @* begin
      case (condCode)
         `COND_NEVER:             testTrue = 1'b0;                       // [RULE3]
         `COND_SIGNED_BELOW:      testTrue = signedBelow;                // [RULE4]
         `COND_SIGNED_BELOW_SAME: testTrue = zeroFlag | signedBelow;     // [RULE5]
         `COND_UNSIGNED_BEL_SAME: testTrue = carryFlag | zeroFlag;       // [RULE7]
         `COND_OVERFLOWED:        testTrue = overflowFlag;               // [RULE9]
         `COND_NEGATIVE_RESULT:   testTrue = signFlag;                   // [RULE10]
         `COND_EQUAL_TEST:        testTrue = zeroFlag;                   // [RULE11]
         `COND_UNSIGNED_BELOW:    testTrue = carryFlag;                  // [RULE12]
         `COND_ALWAYS:            testTrue = 1'b1;                       // [RULE3]
         `COND_SIGNED_ABOVE_SAME: testTrue = ~signedBelow;               // [RULE4]
         `COND_SIGNED_ABOVE:      testTrue = ~(zeroFlag | signedBelow);  // [RULE6]
         `COND_UNSIGNED_ABOVE:    testTrue = ~carryFlag & ~zeroFlag;     // [RULE8]
         `COND_NOT_OVERFLOWED:    testTrue = ~overflowFlag;              // [RULE9]
         `COND_POSITIVE_RESULT:   testTrue = ~signFlag;                  // [RULE10]
         `COND_UNEQUAL_TEST:      testTrue = ~zeroFlag;                  // [RULE11]
         `COND_UNSIGNED_ABV_SAME: testTrue = ~carryFlag;                 // [RULE12]
         default:                 testTrue = 1'b0;
      endcase
   end

endmodule // condition_flag_test

// *** verification/branch_condition_evaluator_sva.sv ***
`timescale 1ns/1ps
// ****
// Decision checker
// ****
module branch_condition_evaluator_sva (
   input wire       clk,
   input wire       rst,
   input wire [7:0] opcodeByte,
   input wire       carryFlag,
   input wire       zeroFlag,
   input wire       signFlag,
   input wire       overflowFlag,
   input wire       jumpTaken,
   input wire [3:0] branchConditionField
);
   // Top bit of the field inverts each test, so one check covers a pair.
   wire [3:0] code = opcodeByte[7:4];
   wire       sxv  = signFlag ^ overflowFlag;
   wire       inv  = code[3];
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   field_copy_a: assert property (branchConditionField == code)
      else $error("condition field copy wrong");
   fixed_codes_a: assert property (
      code[2:0] == 3'h0 |-> jumpTaken == inv)
      else $error("never or always code wrong");
   sign_ovf_a: assert property (
      code[2:0] == 3'h1 |-> jumpTaken == (sxv ^ inv))
      else $error("sign versus overflow test wrong");
   signed_same_a: assert property (
      code[2:0] == 3'h2 |-> jumpTaken == ((zeroFlag | sxv) ^ inv))
      else $error("signed or-same test wrong");
   unsigned_same_a: assert property (
      code[2:0] == 3'h3 |-> jumpTaken == ((carryFlag | zeroFlag) ^ inv))
      else $error("unsigned or-same test wrong");
   overflow_test_a: assert property (
      code[2:0] == 3'h4 |-> jumpTaken == (overflowFlag ^ inv))
      else $error("overflow test wrong");
   sign_test_a: assert property (
      code[2:0] == 3'h5 |-> jumpTaken == (signFlag ^ inv))
      else $error("sign test wrong");
   zero_test_a: assert property (
      code[2:0] == 3'h6 |-> jumpTaken == (zeroFlag ^ inv))
      else $error("zero test wrong");
   carry_test_a: assert property (
      code[2:0] == 3'h7 |-> jumpTaken == (carryFlag ^ inv))
      else $error("carry test wrong");
   stable_decision_a: assert property (
      $stable(opcodeByte) && $stable({carryFlag, zeroFlag, signFlag, overflowFlag})
      |-> $stable(jumpTaken))
      else $error("decision moved with steady inputs");
endmodule // branch_condition_evaluator_sva

bind branch_condition_evaluator branch_condition_evaluator_sva chk_u (.*);

// *** verification/jump_sequencer_model.sv ***
`timescale 1ns/1ps
// ****
// Jump sequencing partner
// ****
module jump_sequencer_model (
   input  wire        clk,
   output logic [7:0] opcodeByte,
   output logic       carryFlag,
   output logic       zeroFlag,
   output logic       signFlag,
   output logic       overflowFlag,
   output logic       resolveStrobe
);
   initial begin
      opcodeByte = 8'h00;
      {overflowFlag, signFlag, zeroFlag, carryFlag} = 4'h0;
      resolveStrobe = 1'b0;
   end
   // Flags move only at an edge, as a completed flag write leaves them.
   task automatic issue(input logic [7:0] op, input logic [3:0] f, input logic st);
      @(posedge clk);
      opcodeByte <= op;
      {overflowFlag, signFlag, zeroFlag, carryFlag} <= f;
      resolveStrobe <= st;
   endtask
endmodule // jump_sequencer_model

// *** verification/branch_condition_evaluator_tb.sv ***
`timescale 1ns/1ps
// ****
// Bench
// ****
module branch_condition_evaluator_tb;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  opcodeByte, op;
   logic [3:0]  fl, branchConditionField;
   logic        carryFlag, zeroFlag, signFlag, overflowFlag, resolveStrobe, jumpTaken;
   int          num_errors, tests_run, cycles, nRes, nTaken;

   branch_condition_evaluator dut_u (.*);
   jump_sequencer_model partner_u (.*);

   function automatic int expTaken(int code, int f);
      int r;
      case (code & 7)
         0: r = 0;
         1: r = f[2] ^ f[3];
         2: r = f[1] | (f[2] ^ f[3]);
         3: r = f[0] | f[1];
         4: r = f[3];
         5: r = f[2];
         6: r = f[1];
         default: r = f[0];
      endcase
      return r ^ (code >> 3);
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // No wait bound here: the global cycle limit ends a stuck slave.
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end

   initial begin
      rst = 1'b1;
      {psel, penable, pwrite} = 3'b000;
      paddr = 12'h000;
      pwdata = 32'h0;
      void'($urandom(32'h87e1eb37));
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         apb(12'(i * 4), 1'b0, 32'h0);
         check(rd, i == 0);
         check(err, i == 6);
      end
      $display("test reset values done");
      for (int code = 0; code < 16; code++)
         for (int f = 0; f < 16; f++) begin
            op = {code[3:0], 4'($urandom)};
            partner_u.issue(op, f[3:0], 1'b1);
            @(negedge clk);
            case (code & 7)
               0, 1:    check(jumpTaken, expTaken(code, f));
               2, 3:    check(jumpTaken, expTaken(code, f));
               4, 5:    check(jumpTaken, expTaken(code, f));
               default: check(jumpTaken, expTaken(code, f));
            endcase
            check(branchConditionField, code);
            nRes++;
            nTaken += expTaken(code, f);
         end
      partner_u.issue(8'h00, 4'h0, 1'b0);
      apb(12'h00c, 1'b0, 32'h0);
      check(rd, nTaken);
      apb(12'h010, 1'b0, 32'h0);
      check(rd, nRes);
      apb(12'h014, 1'b0, 32'h0);
      check(rd, 32'hffff);
      apb(12'h004, 1'b0, 32'h0);
      check(rd, {22'h0, 1'b1, 1'(expTaken(15, 15)), 8'hff});
      $display("test decision table done");
      repeat (40) begin
         op = 8'($urandom);
         fl = 4'($urandom);
         partner_u.issue(op, fl, 1'b0);
         @(negedge clk);
         check(jumpTaken, expTaken(op[7:4], fl));
         apb(12'h008, 1'b1, {24'h0, op[7:4], fl});
         apb(12'h008, 1'b0, 32'h0);
         check(rd, {23'h0, 1'(expTaken(op[7:4], fl)), op[7:4], fl});
      end
      $display("test random trials done");
      apb(12'h000, 1'b1, 32'h2);
      partner_u.issue(8'h80, 4'h0, 1'b1);
      partner_u.issue(8'h80, 4'h0, 1'b0);
      // Seen bits are write-one-to-clear, so writing all ones empties them.
      apb(12'h014, 1'b1, 32'h0000_ffff);
      for (int i = 0; i < 4; i++) begin
         apb(12'(i * 4 + (i > 0) * 8), 1'b0, 32'h0);
         check(rd, 32'h0);
      end
      $display("test count control done");
      report_and_stop();
   end
endmodule // branch_condition_evaluator_tb
